// ### hw/status_event_reporting.sv
// Status byte, standard event register, masks, service request and error queue.
// Assumes an Avalon-MM master on ref_clk and event pulses from same-clock logic.
//
// How it works
// - Each event pulse sets its own standard event bit; operation complete only while armed.
// - Status byte bit 5 is any enabled standard event bit.
// - Reading the event register returns its bits, then clears it.
// - Service request enable mask is writable and readable.
// - Standard event enable mask is writable and readable.
// - Operation and questionable bits are gated by their enables into summaries.
// - Clear status empties events, error queue and pending completion request.
// - Clear status right after a terminator also empties output queue.
// - Error flags sit at positions 2 to 5; mask 60 enables all.
// - Enabled event summary raises the service request output.
// - Disabled event bits still set but add nothing to summary.
// - Status byte bit 4 shows output queue not empty.
// - Error queue stores positive device and negative general codes.
// - Error queue empties on readout, clear status or power-up.
// - Queue keeps older entries on overflow; last slot becomes -350.
// - Queue holds 30 entries, one reserved for overflow.
// - Error read pops the oldest entry; empty returns zero.
// - Status byte summaries follow their sources live.
// - Poll returns bit 6 as request flag and clears it; status read keeps it.
// - Query, execution and command errors at positions 2, 4, 5.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
module status_event_reporting
  import status_event_pkg::*;
#(
  parameter int ErrDepth = status_event_pkg::ErrQueueDepth
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // Event pulses from instrument logic
  input wire logic opCompleteEvt,
  input wire logic request_control_flag,
  input wire logic query_error_flag,
  input wire logic device_error_flag,
  input wire logic execution_error_flag,
  input wire logic commandErrorEvt,
  input wire logic user_request_flag,
  // Error code push
  input wire logic errPush,
  input wire logic signed [15:0] errCode,
  // Operation and questionable condition levels
  input wire logic [15:0] operCond,
  input wire logic [15:0] questCond,
  // Output queue
  input wire logic outQueueNotEmpty,
  output logic outQueueClear,
  // Service request to the controller
  output logic serviceRequest
);
  import status_event_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] event_r, event_nxt;
  logic [7:0] eventEn_r, eventEn_nxt;
  logic [7:0] srqEn_r, srqEn_nxt;
  logic [15:0] operEn_r, operEn_nxt;
  logic [15:0] questEn_r, questEn_nxt;
  logic rqs_r, rqs_nxt;
  logic opcArm_r, opcArm_nxt;
  logic powerUp_r, powerUp_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  logic [1:0] resp_r, resp_nxt;
  logic outClr_r, outClr_nxt;
  // Summary as seen last cycle, so that only a new reason raises a request
  logic mssPrev_r, mssPrev_nxt;

  logic [3:0] idx;
  logic aligned;
  logic req;
  logic take;
  logic [7:0] statusByte;
  logic master_summary_flag;
  logic operSum, questSum, eventSum;
  logic [7:0] evtIn;
  logic clearStatus;
  logic errPop;
  // Accepting edge of a serial poll read
  logic pollTake;
  logic signed [15:0] errHead;
  logic [5:0] errCount;

  //////////////////////////////////////////////////////////////////////////
  // Summaries and status byte
  assign operSum = |(operCond & operEn_r);
  assign questSum = |(questCond & questEn_r);
  assign eventSum = |(event_r & eventEn_r);

  always_comb begin
    statusByte = 8'h00;
    statusByte[QuestSummaryPos] = questSum;
    statusByte[MsgAvailPos] = outQueueNotEmpty;
    statusByte[EventSummaryPos] = eventSum;
    statusByte[OperSummaryPos] = operSum;
  end

  // Master summary excludes bit 6 itself
  assign master_summary_flag = |(statusByte & srqEn_r & 8'hBF);

  // Event inputs mapped to fixed positions
  always_comb begin
    evtIn = 8'h00;
    evtIn[OpCompletePos] = opCompleteEvt & opcArm_r;
    evtIn[ReqControlPos] = request_control_flag;
    evtIn[QueryErrPos] = query_error_flag;
    evtIn[DeviceErrPos] = device_error_flag;
    evtIn[ExecErrPos] = execution_error_flag;
    evtIn[CommandErrPos] = commandErrorEvt;
    evtIn[UserReqPos] = user_request_flag;
    evtIn[PowerOnPos] = powerUp_r;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign idx = address[5:2];
  assign aligned = (address[1:0] == 2'b00);
  assign req = read | write;
  // Single wait cycle: each access is answered on the second edge
  assign take = req & ack_r;
  assign waitrequest = req & ~ack_r;
  assign readdata = readdata_r;
  assign response = resp_r;
  assign outQueueClear = outClr_r;
  assign serviceRequest = rqs_r;

  assign clearStatus = take & write & aligned & (idx == RegControlIdx) & byteenable[0]
    & writedata[CtlClearStatusPos];
  assign errPop = take & read & aligned & (idx == RegErrorIdx);

  // Bus answer: data and response are loaded in the wait cycle, so they
  // stand at the accepting edge; the data then stays until the next request is seen, the response returns to 00
  // Writes load the data register too; it is simply not looked at
  always_comb begin
    ack_nxt = req & ~ack_r;
    readdata_nxt = readdata_r;
    resp_nxt = 2'b00;
    if (req & ~ack_r) begin
      readdata_nxt = 32'h0000_0000;
      if (!aligned) begin
        resp_nxt = 2'b10;
      end else if (idx == RegEventIdx) begin
        readdata_nxt = {24'h00_0000, event_r};
      end else if (idx == RegEventEnIdx) begin
        readdata_nxt = {24'h00_0000, eventEn_r};
      end else if (idx == RegStatusIdx) begin
        readdata_nxt = {24'h00_0000, statusByte | {1'b0, master_summary_flag, 6'h00}};
      end else if (idx == RegSrqEnIdx) begin
        readdata_nxt = {24'h00_0000, srqEn_r};
      end else if (idx == RegPollIdx) begin
        readdata_nxt = {24'h00_0000, statusByte | {1'b0, rqs_r, 6'h00}};
      end else if (idx == RegErrorIdx) begin
        readdata_nxt = {{16{errHead[15]}}, errHead};
      end else if (idx == RegOperEnIdx) begin
        readdata_nxt = {16'h0000, operEn_r};
      end else if (idx == RegQuestEnIdx) begin
        readdata_nxt = {16'h0000, questEn_r};
      end else if (idx == RegControlIdx) begin
        readdata_nxt = {29'h0000_0000, opcArm_r, 2'b00};
      end else if (idx == RegErrCountIdx) begin
        readdata_nxt = {26'h000_0000, errCount};
      end else begin
        resp_nxt = 2'b10;
      end
    end
  end

  // Access takes two cycles: one wait state, then the accepting edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
      resp_r <= 2'b00;
    end else begin
      ack_r <= ack_nxt;
      readdata_r <= readdata_nxt;
      resp_r <= resp_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event register, enable masks and control bits
  // Clear status leaves the masks alone; events, the error queue and the completion arm are emptied
  always_comb begin
    event_nxt = event_r | evtIn;
    eventEn_nxt = eventEn_r;
    srqEn_nxt = srqEn_r;
    operEn_nxt = operEn_r;
    questEn_nxt = questEn_r;
    opcArm_nxt = opcArm_r;
    powerUp_nxt = 1'b0;
    outClr_nxt = 1'b0;
    if (take & read & aligned & (idx == RegEventIdx)) begin
      // Events arriving in the same cycle survive the clear
      event_nxt = evtIn;
    end
    if (take & write & aligned) begin
      if (idx == RegEventEnIdx && byteenable[0]) begin
        eventEn_nxt = writedata[7:0];
      end else if (idx == RegSrqEnIdx && byteenable[0]) begin
        srqEn_nxt = writedata[7:0] & 8'hBF;
      end else if (idx == RegOperEnIdx) begin
        if (byteenable[0]) operEn_nxt[7:0] = writedata[7:0];
        if (byteenable[1]) operEn_nxt[15:8] = writedata[15:8];
      end else if (idx == RegQuestEnIdx) begin
        if (byteenable[0]) questEn_nxt[7:0] = writedata[7:0];
        if (byteenable[1]) questEn_nxt[15:8] = writedata[15:8];
      end else if (idx == RegControlIdx && byteenable[0]) begin
        if (writedata[CtlOpcArmPos]) begin
          opcArm_nxt = 1'b1;
        end
        if (writedata[CtlClearStatusPos]) begin
          event_nxt = evtIn & ~{7'h00, opcArm_r};
          opcArm_nxt = 1'b0;
          outClr_nxt = writedata[CtlAfterTermPos];
        end
      end
    end
  end

  // Power-on flag is loaded by the first edge after reset releases
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_r <= ResetMask8;
      eventEn_r <= ResetMask8;
      srqEn_r <= ResetMask8;
      operEn_r <= ResetMask16;
      questEn_r <= ResetMask16;
      opcArm_r <= 1'b0;
      powerUp_r <= 1'b1;
      outClr_r <= 1'b0;
    end else begin
      event_r <= event_nxt;
      eventEn_r <= eventEn_nxt;
      srqEn_r <= srqEn_nxt;
      operEn_r <= operEn_nxt;
      questEn_r <= questEn_nxt;
      opcArm_r <= opcArm_nxt;
      powerUp_r <= powerUp_nxt;
      outClr_r <= outClr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Service request: raised by a new enabled reason, so a poll really
  // withdraws it; a reason that merely stays does not raise it again
  assign pollTake = take & read & aligned & (idx == RegPollIdx);

  always_comb begin
    rqs_nxt = rqs_r | (master_summary_flag & ~mssPrev_r);
    // A reason that appears during the poll is seen one cycle later
    mssPrev_nxt = pollTake ? mssPrev_r : master_summary_flag;
    if (pollTake) begin
      rqs_nxt = 1'b0;
    end
    // Withdrawn at once when no enabled reason is left
    if (!master_summary_flag) begin
      rqs_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rqs_r <= 1'b0;
      mssPrev_r <= 1'b0;
    end else begin
      rqs_r <= rqs_nxt;
      mssPrev_r <= mssPrev_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Error queue, cleared by clear status and emptied at reset
  error_queue #(
    .Depth(ErrDepth),
    .OvfCode(OverflowCode),
    .EmptyCode(NoErrorCode)
  ) errQueue (
    .clk(ref_clk),
    .resetN(reset_n),
    .clear(clearStatus),
    .push(errPush),
    .pushCode(errCode),
    .pop(errPop),
    .headCode(errHead),
    .count(errCount)
  );

endmodule

// ### hw/status_event_pkg.sv
// Constants shared by the status and event reporting block.
// Assumes a single 250 MHz instrument clock and one asynchronous reset.
package status_event_pkg;

  // Standard event register positions
  localparam int OpCompletePos = 0;
  localparam int ReqControlPos = 1;
  localparam int QueryErrPos = 2;
  localparam int DeviceErrPos = 3;
  localparam int ExecErrPos = 4;
  localparam int CommandErrPos = 5;
  localparam int UserReqPos = 6;
  localparam int PowerOnPos = 7;
  localparam logic [7:0] ErrorEventMask = 8'h3C;

  // Status byte positions
  localparam int QuestSummaryPos = 3;
  localparam int MsgAvailPos = 4;
  localparam int EventSummaryPos = 5;
  localparam int ServiceReqPos = 6;
  localparam int OperSummaryPos = 7;

  // Error queue
  localparam int ErrQueueDepth = 30;
  localparam logic signed [15:0] OverflowCode = -16'sd350;
  localparam logic signed [15:0] NoErrorCode = 16'h0000;

  // Register word offsets (byte address = 4 * index)
  localparam logic [3:0] RegEventIdx = 4'h0;
  localparam logic [3:0] RegEventEnIdx = 4'h1;
  localparam logic [3:0] RegStatusIdx = 4'h2;
  localparam logic [3:0] RegSrqEnIdx = 4'h3;
  localparam logic [3:0] RegPollIdx = 4'h4;
  localparam logic [3:0] RegErrorIdx = 4'h5;
  localparam logic [3:0] RegOperEnIdx = 4'h6;
  localparam logic [3:0] RegQuestEnIdx = 4'h7;
  localparam logic [3:0] RegControlIdx = 4'h8;
  localparam logic [3:0] RegErrCountIdx = 4'h9;

  // Control register bits
  localparam int CtlClearStatusPos = 0;
  localparam int CtlAfterTermPos = 1;
  localparam int CtlOpcArmPos = 2;

  localparam logic [15:0] ResetMask16 = 16'h0000;
  localparam logic [7:0] ResetMask8 = 8'h00;

endpackage

// ### hw/error_queue.sv
// First-in first-out error code queue with overflow marker slot.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ns
module error_queue #(
  parameter int Depth = 30,
  parameter logic signed [15:0] OvfCode = -16'sd350,
  parameter logic signed [15:0] EmptyCode = 16'h0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetN,
  // Control
  input wire logic clear,
  input wire logic push,
  input wire logic signed [15:0] pushCode,
  input wire logic pop,
  // Status
  output logic signed [15:0] headCode,
  output logic [5:0] count
);
  logic signed [15:0] mem [Depth];
  logic [5:0] count_r, count_nxt;
  logic signed [15:0] memIn;
  logic doWrite, doShift;

  //////////////////////////////////////////////////////////////////////////
  // Shift queue: head is always slot 0, so a pop is a one-cycle shift
  always_comb begin
    count_nxt = count_r;
    doWrite = 1'b0;
    doShift = 1'b0;
    memIn = pushCode;
    if (clear) begin
      count_nxt = '0;
    end else begin
      if (pop && count_r != '0) begin
        doShift = 1'b1;
      end
      // Last slot is kept for the overflow marker; newest error dropped
      if (push && !(doShift && count_r == 6'(Depth))) begin
        if (count_r - 6'(doShift) < 6'(Depth - 1)) begin
          doWrite = 1'b1;
        end else if (count_r - 6'(doShift) == 6'(Depth - 1)) begin
          doWrite = 1'b1;
          memIn = OvfCode;
        end
      end
      count_nxt = count_r - 6'(doShift) + 6'(doWrite);
    end
  end

  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < Depth; i++) begin
      if (doShift && i < Depth - 1) begin
        mem[i] <= mem[i + 1];
      end
      if (doWrite && 6'(i) == count_r - 6'(doShift)) begin
        mem[i] <= memIn;
      end
    end
  end

  assign headCode = (count_r == '0) ? EmptyCode : mem[0];
  assign count = count_r;
endmodule

// ### dv/output_queue_model.sv
// Controller-side output queue: a byte counter.
// Assumes the bench loads bytes and the block empties it with a pulse.
`timescale 1ns/1ns
module output_queue_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Queue traffic
  input wire logic [7:0] load,
  input wire logic outQueueClear,
  output logic outQueueNotEmpty
);
  logic [9:0] count_r;
  logic [9:0] count_nxt;
  always_comb begin
    count_nxt = count_r + 10'(load);
    if (outQueueClear) begin
      count_nxt = '0;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end
  // Level, not registered: the status byte must see an empty queue at once
  assign outQueueNotEmpty = (count_r != 10'h000);
endmodule

// ### dv/status_event_properties.sv
// Port-level checks for the status and event reporting block.
// Assumes it is bound onto status_event_reporting and sees only its ports.
`timescale 1ns/1ns
module status_event_properties #(
  parameter int ErrDepth = 30
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  input wire logic outQueueClear,
  input wire logic serviceRequest
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic acc;
  assign acc = (read || write) && !waitrequest;
  ////////////////////////////////////////////////////////////////////
  a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request waited more than one cycle");
  a_idle_ready: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high while idle");
  a_bad_align: assert property (acc && address[1:0] != 2'b00 |-> response == 2'b10)
    else $error("unaligned access not refused");
  a_bad_index: assert property (acc && address[5:2] > 4'h9 |-> response == 2'b10)
    else $error("unmapped access not refused");
  a_good_okay: assert property (acc && address[1:0] == 2'b00 && address[5:2] <= 4'h9
    |-> response == 2'b00) else $error("mapped access refused");
  a_data_stands: assert property (acc ##1 !(read || write) |-> $stable(readdata))
    else $error("read data changed while idle");
  a_clear_pulse: assert property (outQueueClear |=> !outQueueClear)
    else $error("output queue clear longer than one cycle");
  a_clear_cause: assert property ($rose(outQueueClear) |->
    $past(write && !waitrequest && address == 6'h20 && writedata[1]))
    else $error("output queue clear without command");
  a_poll_drops: assert property (read && !waitrequest && address == 6'h10
    |=> !serviceRequest) else $error("poll did not withdraw service request");
  a_event_byte: assert property (acc && read && address == 6'h00
    |-> readdata[31:8] == 24'h00_0000) else $error("event read wider than a byte");
endmodule
bind status_event_reporting status_event_properties #(.ErrDepth(ErrDepth))
  u_status_event_properties (.ref_clk, .reset_n, .address, .read, .write, .writedata,
  .readdata, .waitrequest, .response, .outQueueClear, .serviceRequest);

// ### dv/tb_status_event_reporting.sv
// Self-checking bench for the status and event reporting block.
// Assumes the output queue model stands on the controller side.
`timescale 1ns/1ns
module tb_status_event_reporting;
  import status_event_pkg::*;
  logic ref_clk = 0, reset_n = 0, read = 0, write = 0, errPush = 0;
  logic waitrequest, outQueueClear, serviceRequest, outQueueNotEmpty;
  logic [5:0] address = '0;
  logic [31:0] writedata = '0, readdata, r;
  logic [1:0] response;
  logic [6:0] evt = '0;
  logic signed [15:0] errCode = '0, p;
  logic [15:0] operCond = '0, questCond = '0;
  logic [7:0] load = '0;
  logic [33:0] expQ[$], mskQ[$];
  int num_errors = 0, n_checks = 0, cyc = 0, seed = 87, k;
  always #2 ref_clk = ~ref_clk;
  status_event_reporting u_status_event_reporting (.ref_clk, .reset_n, .address, .read,
    .write, .writedata, .byteenable(4'hF), .readdata, .waitrequest, .response,
    .opCompleteEvt(evt[0]), .request_control_flag(evt[1]), .query_error_flag(evt[2]),
    .device_error_flag(evt[3]), .execution_error_flag(evt[4]), .commandErrorEvt(evt[5]),
    .user_request_flag(evt[6]), .errPush, .errCode, .operCond, .questCond,
    .outQueueNotEmpty, .outQueueClear, .serviceRequest);
  output_queue_model u_output_queue_model (.ref_clk, .reset_n, .load, .outQueueClear,
    .outQueueNotEmpty);
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Results are taken at the accepting edge, before that edge's updates land
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end else if (read && waitrequest === 1'b0 && expQ.size() > 0) begin
      chk({response, readdata} & mskQ.pop_front(), expQ.pop_front());
    end
  end
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    // Held until the rising edge that samples waitrequest low
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [33:0] e, input logic [33:0] m = '1);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    evt <= 7'(1 << i);
    @(posedge ref_clk);
    evt <= '0;
  endtask
  task automatic push(input logic signed [15:0] c);
    @(posedge ref_clk);
    errPush <= 1'b1;
    errCode <= c;
    @(posedge ref_clk);
    errPush <= 1'b0;
  endtask
  task automatic srq(input logic v);
    for (int j = 0; j < 8 && serviceRequest !== v; j++) @(negedge ref_clk);
    chk({33'h0, serviceRequest}, {33'h0, v});
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(6'h00, 34'h80);
    rd(6'h00, 34'h0);
    rd(6'h04, 34'h0);
    rd(6'h0C, 34'h0);
    rd(6'h14, 34'h0);
    wr(6'h20, 32'h0000_0004);
    rd(6'h20, 34'h4, 34'h4);
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      rd(6'h00, 34'(1 << i));
    end
    pulse(3);
    wr(6'h20, 32'h0000_0001);
    rd(6'h00, 34'h0);
    rd(6'h20, 34'h0, 34'h4);
    $display("test events done");
    wr(6'h04, 32'h0000_003C);
    rd(6'h04, 34'h3C);
    pulse(6);
    rd(6'h08, 34'h0, 34'h20);
    k = 2 + ($unsigned($random(seed)) % 4);
    pulse(k);
    rd(6'h08, 34'h20, 34'h20);
    wr(6'h0C, 32'h0000_0020);
    rd(6'h0C, 34'h20);
    srq(1'b1);
    rd(6'h10, 34'h60, 34'h60);
    rd(6'h08, 34'h60, 34'h60);
    rd(6'h00, 34'(32'h40 | (1 << k)));
    rd(6'h08, 34'h0, 34'h60);
    srq(1'b0);
    $display("test summary done");
    @(posedge ref_clk);
    load <= 8'h03;
    @(posedge ref_clk);
    load <= 8'h00;
    rd(6'h08, 34'h10, 34'h10);
    wr(6'h20, 32'h0000_0001);
    rd(6'h08, 34'h10, 34'h10);
    wr(6'h20, 32'h0000_0003);
    rd(6'h08, 34'h0, 34'h10);
    r = $random(seed);
    @(posedge ref_clk);
    operCond <= r[15:0] | 16'h0001;
    questCond <= r[31:16] | 16'h0008;
    rd(6'h08, 34'h0, 34'h88);
    wr(6'h18, {16'h0000, operCond});
    wr(6'h1C, {16'h0000, ~questCond});
    rd(6'h08, 34'h80, 34'h88);
    $display("test status byte done");
    p = {1'b0, r[14:0]} | 16'sh0001;
    push(p);
    push(-p);
    rd(6'h14, 34'(p));
    rd(6'h14, {2'b00, {16{1'b1}}, 16'(-p)});
    rd(6'h14, 34'h0);
    for (int i = 1; i <= 31; i++) push(16'(i));
    for (int i = 1; i <= 29; i++) rd(6'h14, 34'(i));
    rd(6'h14, 34'h0_FFFF_FEA2);
    rd(6'h14, 34'h0);
    push(16'sh0009);
    wr(6'h20, 32'h0000_0001);
    rd(6'h14, 34'h0);
    rd(6'h02, 34'h2_0000_0000);
    rd(6'h28, 34'h2_0000_0000);
    $display("test error queue done");
    end_sim();
  end
endmodule
